//--- core/ch2_tx_input_bit6_mux.sv
// Selector for the shared channel 2 transmit bit 6 pin: add bus, HDLC byte bus or serial payload.
// Assumes mode inputs are static core levels and the link clocks come from the far-end equipment.
`timescale 1ns/10ps
// Behaviour
// (R1) Add bus enabled: pin is add bit 6.
// (R2) Add bus bit sampled on falling clock edge.
// (R3) Add bus disabled: mode picks HDLC or serial.
// (R4) HDLC mode: pin is HDLC input bit 6.
// (R5) HDLC mode: drive byte-rate HDLC clock out; the code drives one clock rise per bit, eight rises per byte.
// (R6) HDLC bits sampled at clock-out rising edge.
// (R7) Far end supplies all serial payload bits.
// (R8) Serial payload sampled on input clock rising edge.
// (R9) One-period frame pulse on last frame bit.
module ch2_tx_input_bit6_mux
#(
    parameter logic [ch2_bit6_pkg::FRAME_CNT_W-1:0] FRAME_BITS = ch2_bit6_pkg::FRAME_BITS_DEF // Bits per frame.
)
(
    input  wire logic                 core_clk,                // Core clock, 40 MHz.
    input  wire logic                 nrst,                    // Asynchronous reset, active low.
    input  wire logic                 addBusEnable,            // Add telecom bus enabled.
    input  wire logic                 hdlcModeSel,             // HDLC mode when add bus is off.
    input  wire logic                 bit6Pin,                 // Shared bit 6 input pin.
    input  wire logic                 ch2_add_bus_clock,       // Add bus clock.
    input  wire logic                 tx_serial_input_clock,   // Serial payload clock.
    output      logic                 ch2_hdlc_byte_clock_out, // HDLC byte clock driven out.
    output      logic                 ch2_frame_boundary_out,  // Frame boundary pulse, serial clock domain.
    output      ch2_bit6_pkg::role_t  roleNow,                 // Current pin role.
    output      logic [7:0]           bit6Word,                // Last eight bit 6 samples, newest in bit 0.
    output      logic                 bit6Valid                // One-cycle pulse with a new word.
);
    import ch2_bit6_pkg::*;

    logic [1:0] rstPipe_r;
    logic       pinS1_r;
    logic       pinS2_r;
    logic [2:0] divCnt_r;
    logic       hdlcClk_r;
    logic [7:0] hdlcSh_r;
    logic [2:0] hdlcCnt_r;
    logic [7:0] bit6Word_r;
    logic       bit6Valid_r;
    logic [2:0] togSync_r [2];
    logic [7:0] linkWord [2];
    logic [1:0] linkNew;
    logic [1:0] linkClks;
    logic [1:0] linkEn;

    link_word_if lw [2] ();

    wire   rstN = rstPipe_r[1];
    role_t role;

    // The add bus enable overrides the mode select, so both set still means add bus.
    assign role = addBusEnable ? ROLE_ADD : (hdlcModeSel ? ROLE_HDLC : ROLE_SERIAL); // see (R1) (R3)

    wire isHdlc      = (role == ROLE_HDLC);                     // see (R4)
    wire divWrap     = (divCnt_r == HDLC_HALF_CYC - 1'b1);
    wire hdlcRise    = isHdlc && divWrap && !hdlcClk_r;         // see (R6)
    wire hdlcByteDone = hdlcRise && (hdlcCnt_r == LAST_BIT_IDX);
    wire [7:0] hdlcShNxt = {hdlcSh_r[6:0], pinS2_r};
    wire addNew      = (role == ROLE_ADD) && linkNew[0];
    wire serialNew   = (role == ROLE_SERIAL) && linkNew[1];

    assign linkClks = {tx_serial_input_clock, ch2_add_bus_clock};
    assign linkEn   = {role == ROLE_SERIAL, role == ROLE_ADD};

    // Bytes are packed on the link clock so one toggle per eight bits is slow enough to cross.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_link
            link_capture
            #(
                .NEG_EDGE    (gi == 0),
                .COUNT_FRAME (gi == 1),
                .FRAME_BITS  (FRAME_BITS)
            )
            u_cap
            (
                .linkClk (linkClks[gi]),
                .rstN    (rstN),
                .enable  (linkEn[gi]),
                .pinIn   (bit6Pin),
                .lw      (lw[gi])
            );

            assign linkWord[gi] = lw[gi].word;
            assign linkNew[gi]  = togSync_r[gi][2] ^ togSync_r[gi][1];

            always_ff @(posedge core_clk or negedge rstN)
            begin
                if (!rstN)
                    togSync_r[gi] <= 3'h0;
                else
                    togSync_r[gi] <= {togSync_r[gi][1:0], lw[gi].tog};
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            rstPipe_r <= 2'h0;
        else
            rstPipe_r <= {rstPipe_r[0], 1'b1};
    end

    // Only the HDLC path reads the pin on the core clock, so only it needs these two flops.
    // The far end must therefore hold each bit for at least two core cycles before the byte clock rises.
    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            pinS1_r <= 1'b0;
            pinS2_r <= 1'b0;
        end
        else
        begin
            pinS1_r <= bit6Pin;
            pinS2_r <= pinS1_r;
        end
    end

    // The clock is parked low outside HDLC mode so the far end sees no stray edges.
    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            divCnt_r  <= 3'h0;
            hdlcClk_r <= 1'b0;
        end
        else
        begin
            divCnt_r  <= (!isHdlc || divWrap) ? 3'h0 : divCnt_r + 1'b1;
            hdlcClk_r <= isHdlc && (divWrap ? ~hdlcClk_r : hdlcClk_r); // see (R5)
        end
    end

    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            hdlcSh_r  <= 8'h00;
            hdlcCnt_r <= 3'h0;
        end
        else if (hdlcRise)
        begin
            hdlcSh_r  <= hdlcShNxt;                             // see (R6)
            hdlcCnt_r <= hdlcCnt_r + 1'b1;
        end
    end

    // Roles are exclusive, so at most one source claims a cycle.
    // Each source is gated by the current role, so a word still in flight across a role change is dropped and the priority order never decides.
    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            bit6Word_r  <= 8'h00;
            bit6Valid_r <= 1'b0;
        end
        else
        begin
            bit6Valid_r <= addNew || serialNew || hdlcByteDone;
            if (addNew)
                bit6Word_r <= linkWord[0];                      // see (R1)
            else if (serialNew)
                bit6Word_r <= linkWord[1];                      // see (R8)
            else if (hdlcByteDone)
                bit6Word_r <= hdlcShNxt;                        // see (R4)
        end
    end

    assign ch2_hdlc_byte_clock_out = hdlcClk_r;
    assign ch2_frame_boundary_out  = lw[1].framePulse;          // see (R9)
    assign roleNow                 = role;
    assign bit6Word                = bit6Word_r;
    assign bit6Valid               = bit6Valid_r;

    // Core-domain checks; the checks on the link edges sit in the capture stage.
    AST_ADD_WORD_SELECT: assert property ( // see (R1)
        @(posedge core_clk) disable iff (!rstN)
        addNew |=> bit6Valid_r && (bit6Word_r == $past(linkWord[0])))
        else $error("Add bus word not delivered.");

    AST_ROLE_NO_HDLC_CLOCK: assert property ( // see (R3)
        @(posedge core_clk) disable iff (!rstN)
        !isHdlc |=> !hdlcClk_r && (divCnt_r == 3'h0))
        else $error("HDLC clock running outside HDLC mode.");

    AST_HDLC_WORD_SELECT: assert property ( // see (R4)
        @(posedge core_clk) disable iff (!rstN)
        hdlcByteDone |=> bit6Valid_r && (bit6Word_r == $past(hdlcShNxt)))
        else $error("HDLC word not delivered.");

    AST_HDLC_CLOCK_HALF: assert property ( // see (R5)
        @(posedge core_clk) disable iff (!rstN)
        ($rose(hdlcClk_r) && isHdlc ##1 isHdlc[*3]) |-> hdlcClk_r ##1 !hdlcClk_r)
        else $error("HDLC clock half period is not four core cycles.");

    AST_HDLC_SAMPLE_ON_RISE: assert property ( // see (R6)
        @(posedge core_clk) disable iff (!rstN)
        (hdlcCnt_r != $past(hdlcCnt_r)) |-> $past(hdlcRise) && $rose(hdlcClk_r))
        else $error("HDLC bit taken away from the clock rising edge.");

    AST_VALID_HAS_CAUSE: assert property ( // see (R3)
        @(posedge core_clk) disable iff (!rstN)
        bit6Valid_r |-> $past(addNew) || $past(serialNew) || $past(hdlcByteDone))
        else $error("Word valid without a source in the selected role.");

    AST_SERIAL_WORD_SELECT: assert property ( // see (R8)
        @(posedge core_clk) disable iff (!rstN)
        serialNew |=> bit6Valid_r && (bit6Word_r == $past(linkWord[1])))
        else $error("Serial payload word not delivered.");

    AST_HDLC_CLOCK_LOW_HALF: assert property ( // see (R5)
        @(posedge core_clk) disable iff (!rstN)
        $rose(hdlcClk_r) |-> !$past(hdlcClk_r, 2) && !$past(hdlcClk_r, 3) && !$past(hdlcClk_r, 4))
        else $error("HDLC clock low half shorter than four core cycles.");

    AST_HDLC_BIT_FROM_SYNC: assert property ( // see (R6)
        @(posedge core_clk) disable iff (!rstN)
        hdlcRise |=> (hdlcSh_r[0] == $past(pinS2_r)))
        else $error("HDLC bit not taken from the synchronised pin.");

    AST_HDLC_COUNT_HOLDS: assert property ( // see (R3)
        @(posedge core_clk) disable iff (!rstN)
        !isHdlc |=> (hdlcCnt_r == $past(hdlcCnt_r)))
        else $error("HDLC bit count moved outside HDLC mode.");

endmodule : ch2_tx_input_bit6_mux

//--- core/ch2_bit6_pkg.sv
// Shared constants and types for the channel 2 transmit bit 6 pin selector.
// Assumes a 40 MHz core clock and link clocks supplied by the far-end equipment.
package ch2_bit6_pkg;

    localparam int          WORD_BITS      = 8;
    localparam logic [2:0]  LAST_BIT_IDX   = 3'h7;
    localparam logic [2:0]  HDLC_HALF_CYC  = 3'h4;
    localparam int          FRAME_CNT_W    = 13;
    localparam logic [12:0] FRAME_BITS_DEF = 13'h1298;

    // Gray-coded pin roles.
    typedef enum logic [1:0]
    {
        ROLE_ADD    = 2'b01,
        ROLE_HDLC   = 2'b11,
        ROLE_SERIAL = 2'b10
    } role_t;

endpackage : ch2_bit6_pkg

//--- core/link_word_if.sv
// Carrier between a link-domain capture stage and the core-domain selector.
// Assumes word stays stable for a whole byte of link clocks after each toggle.
`timescale 1ns/10ps
interface link_word_if;
    logic [7:0] word;
    logic       tog;
    logic       framePulse;

    modport src
    (
        output word,
        output tog,
        output framePulse
    );
    modport dst
    (
        input word,
        input tog,
        input framePulse
    );
endinterface : link_word_if

//--- core/link_capture.sv
// Capture stage on a link clock: shifts the pin in, packs eight samples and flags each byte by a toggle.
// Assumes rstN is the core's synchronised reset and enable is a quasi-static core level.
`timescale 1ns/10ps
module link_capture
#(
    parameter bit                                        NEG_EDGE    = 1'b0,
    parameter bit                                        COUNT_FRAME = 1'b0,
    parameter logic [ch2_bit6_pkg::FRAME_CNT_W-1:0]     FRAME_BITS  = ch2_bit6_pkg::FRAME_BITS_DEF
)
(
    input  wire logic linkClk, // Link clock from the far end.
    input  wire logic rstN,    // Core reset, released here through the link clock.
    input  wire logic enable,  // Core level enabling this capture path.
    input  wire logic pinIn,   // Shared bit 6 pin.
    link_word_if.src  lw       // Packed byte, toggle and frame pulse.
);
    import ch2_bit6_pkg::*;

    logic [1:0]             rstSync_r;
    logic [1:0]             enSync_r;
    logic [7:0]             sh_r;
    logic [7:0]             word_r;
    logic [2:0]             bitCnt_r;
    logic                   tog_r;
    logic [FRAME_CNT_W-1:0] frameCnt_r;
    logic                   framePulse_r;

    // A static inversion keeps one body for both edge choices.
    wire                   sampClk    = NEG_EDGE ? ~linkClk : linkClk;
    wire                   linkRstN   = rstSync_r[1];
    wire                   en         = enSync_r[1];
    wire [7:0]             shNxt      = {sh_r[6:0], pinIn};
    wire                   wordDone   = en && (bitCnt_r == LAST_BIT_IDX);
    wire                   lastBit    = COUNT_FRAME && en && (frameCnt_r == FRAME_BITS - 1'b1);
    wire [FRAME_CNT_W-1:0] frameCntNxt = (!en || lastBit) ? '0 : frameCnt_r + 1'b1;

    always_ff @(posedge sampClk or negedge rstN)
    begin
        if (!rstN)
            rstSync_r <= 2'h0;
        else
            rstSync_r <= {rstSync_r[0], 1'b1};
    end

    always_ff @(posedge sampClk or negedge linkRstN)
    begin
        if (!linkRstN)
            enSync_r <= 2'h0;
        else
            enSync_r <= {enSync_r[0], enable};
    end

    always_ff @(posedge sampClk or negedge linkRstN)
    begin
        if (!linkRstN)
        begin
            sh_r         <= 8'h00;
            bitCnt_r     <= 3'h0;
            word_r       <= 8'h00;
            tog_r        <= 1'b0;
            frameCnt_r   <= '0;
            framePulse_r <= 1'b0;
        end
        else
        begin
            sh_r         <= en ? shNxt : sh_r;                 // see (R2) (R8)
            bitCnt_r     <= en ? bitCnt_r + 1'b1 : 3'h0;
            word_r       <= wordDone ? shNxt : word_r;
            tog_r        <= wordDone ? ~tog_r : tog_r;
            frameCnt_r   <= frameCntNxt;
            framePulse_r <= lastBit;                           // see (R9)
        end
    end

    assign lw.word       = word_r;
    assign lw.tog        = tog_r;
    assign lw.framePulse = framePulse_r;

    generate
        if (NEG_EDGE)
        begin : g_neg
            AST_ADD_FALL_CAPTURE: assert property ( // see (R2)
                @(posedge sampClk) disable iff (!linkRstN)
                wordDone |=> (word_r == $past(shNxt)) && (tog_r != $past(tog_r)))
                else $error("Add bus byte not packed on the falling edge.");
        end
        else
        begin : g_pos
            AST_SERIAL_RISE_CAPTURE: assert property ( // see (R8)
                @(posedge sampClk) disable iff (!linkRstN)
                wordDone |=> (word_r == $past(shNxt)) && (tog_r != $past(tog_r)))
                else $error("Serial payload byte not packed on the rising edge.");
        end
    endgenerate

    AST_FRAME_PULSE_SINGLE: assert property ( // see (R9)
        @(posedge sampClk) disable iff (!linkRstN)
        framePulse_r |=> !framePulse_r)
        else $error("Frame boundary pulse longer than one line clock.");

    AST_FRAME_PULSE_AT_LAST: assert property ( // see (R9)
        @(posedge sampClk) disable iff (!linkRstN)
        lastBit |=> framePulse_r && (frameCnt_r == '0))
        else $error("Frame boundary pulse missing after the last frame bit.");

endmodule : link_capture

//--- bench/far_end_source.sv
// Far-end terminal equipment model driving the shared bit 6 pin and the link clocks.
// Assumes the testbench calls its tasks one at a time.
`timescale 1ns/10ps
module far_end_source
(
    input  wire logic hdlcClk, // Byte clock from the selector.
    output      logic pin,     // Shared bit 6 pin.
    output      logic addClk,  // Add bus clock, idles high.
    output      logic serClk   // Serial payload clock, idles low.
);
    initial
    begin
        pin    = 1'b0;
        addClk = 1'b1;
        serClk = 1'b0;
    end

    // Link clocks run only inside a burst, so the core never sees a free-running clock.
    task automatic linkBits(input logic [7:0] b, input int n, input bit useAdd);
        for (int i = 7; i > 7 - n; i--)
        begin
            pin = b[i];
            #16;
            if (useAdd) addClk = 1'b0; else serClk = 1'b1;
            #16;
            if (useAdd) addClk = 1'b1; else serClk = 1'b0;
        end
    endtask : linkBits

    task automatic hdlcByte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            pin = b[i];
            @(posedge hdlcClk);
            #2;
        end
    endtask : hdlcByte

    // Outside a transfer the pin no longer holds data.
    task automatic idle;
        pin = ~pin;
    endtask : idle
endmodule : far_end_source

//--- bench/ch2_tx_input_bit6_mux_test.sv
// Self-checking bench for the bit 6 pin selector: serial, add bus and HDLC roles.
// Assumes the far-end model supplies all link clocks and pin data.
`timescale 1ns/10ps
module ch2_tx_input_bit6_mux_test;
    import ch2_bit6_pkg::*;
    localparam logic [12:0] FRAME_BITS = 13'h0010;
    logic       core_clk, nrst, addBusEnable, hdlcModeSel;
    logic       bit6Pin, addClk, serClk, hdlcClk, framePulse, bit6Valid;
    role_t      roleNow;
    logic [7:0] bit6Word, b;
    logic [7:0] expQ[$];
    int         mismatches, num_checks, pulses;
    realtime    t0;

    ch2_tx_input_bit6_mux #(.FRAME_BITS(FRAME_BITS)) ch2_tx_input_bit6_mux_inst
    (
        .core_clk(core_clk), .nrst(nrst), .addBusEnable(addBusEnable), .hdlcModeSel(hdlcModeSel),
        .bit6Pin(bit6Pin), .ch2_add_bus_clock(addClk), .tx_serial_input_clock(serClk),
        .ch2_hdlc_byte_clock_out(hdlcClk), .ch2_frame_boundary_out(framePulse),
        .roleNow(roleNow), .bit6Word(bit6Word), .bit6Valid(bit6Valid)
    );
    far_end_source far_end_source_inst
    (
        .hdlcClk(hdlcClk), .pin(bit6Pin), .addClk(addClk), .serClk(serClk)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    // Each word must match the oldest byte the far end sent; the falling edge sees the pulse settled.
    always @(negedge core_clk)
        if (bit6Valid === 1'b1)
            check("word", (expQ.size() > 0) ? expQ.pop_front() : 8'hXX, bit6Word);

    always @(negedge serClk)
        if (framePulse === 1'b1)
            pulses++;

    task automatic setMode(input logic [1:0] m);
        @(posedge core_clk);
        #2 {addBusEnable, hdlcModeSel} = m;
        repeat (4) @(posedge core_clk);
    endtask : setMode

    task automatic linkStream(input bit useAdd);
        far_end_source_inst.linkBits(8'h00, 4, useAdd);
        for (int k = 0; k < 3; k++)
        begin
            b = 8'($urandom);
            expQ.push_back(b);
            far_end_source_inst.linkBits(b, 8, useAdd);
        end
        far_end_source_inst.idle();
        repeat (20) @(posedge core_clk);
        check("pending words", 8'h00, 8'(expQ.size()));
    endtask : linkStream

    initial
    begin
        void'($urandom(5));
        {nrst, addBusEnable, hdlcModeSel} = 3'h0;
        mismatches = 0;
        num_checks = 0;
        pulses     = 0;
        repeat (12) @(posedge core_clk);
        #2 nrst = 1'b1;
        setMode(2'b00);
        check("serial role", 8'(ROLE_SERIAL), 8'(roleNow));
        check("idle byte clock", 8'h00, {7'h0, hdlcClk});
        linkStream(1'b0);
        // Three bytes pass twenty-four bits, so exactly one sixteen-bit frame ends.
        check("frame pulses", 8'h01, 8'(pulses));
        $display("test serial done");
        // The add bus must win with the HDLC selection set as well.
        setMode(2'b11);
        check("add role", 8'(ROLE_ADD), 8'(roleNow));
        linkStream(1'b1);
        check("parked byte clock", 8'h00, {7'h0, hdlcClk});
        $display("test add bus done");
        // The leading bit goes out with the mode change, since the first clock rise already takes a bit.
        @(posedge core_clk);
        #2 {addBusEnable, hdlcModeSel} = 2'b01;
        for (int k = 0; k < 3; k++)
        begin
            b = 8'($urandom);
            expQ.push_back(b);
            far_end_source_inst.hdlcByte(b);
        end
        check("hdlc role", 8'(ROLE_HDLC), 8'(roleNow));
        far_end_source_inst.idle();
        @(posedge hdlcClk);
        t0 = $realtime;
        @(posedge hdlcClk);
        check("byte clock cycles", 8'(2 * HDLC_HALF_CYC), 8'(int'(($realtime - t0) / 25.0)));
        repeat (10) @(posedge core_clk);
        check("pending words", 8'h00, 8'(expQ.size()));
        $display("test hdlc done");
        tally_and_finish();
    end

    initial
    begin
        #100000;
        mismatches++;
        tally_and_finish();
    end
endmodule : ch2_tx_input_bit6_mux_test
